// ---- hdl/pmc_pad_mode_clk_out.sv ----
// Purpose: pin mode registers for port1 pins 12..15 and clock-to-pin select
// Assumes: one clock, APB slave with one wait state, asynchronous reset
// Notes:   unmapped addresses answer with pslverr and read zero
`default_nettype none
module pmc_pad_mode_clk_out #(
  parameter int NUM_PINS = 4
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output var  logic [31:0]       prdata,
  output var  logic              pready,
  output var  logic              pslverr,
  input  wire logic [NUM_PINS-1:0] adc_mode,
  input  wire logic              divided_system_clock,
  input  wire logic              internal_rc_oscillator,
  input  wire logic              crystal_oscillator_clock,
  output var  pmc_pkg::pmc_pad_t pad_ctrl [NUM_PINS],
  output var  logic              port0_pin8_clk,
  output var  logic              port1_pin2_clk,
  output var  logic              port0_pin11_clk
);
  if (NUM_PINS < 1 || NUM_PINS > pmc_pkg::MAX_PINS) begin : g_bad_pins
    $error("NUM_PINS must lie between 1 and 4");
  end

  // register state
  logic [15:0]          mode_r   [NUM_PINS];
  logic [15:0]          mode_nxt [NUM_PINS];
  logic [15:0]          clk_r;
  logic [15:0]          clk_nxt;

  // bus state
  pmc_pkg::pmc_apb_st_t st_r;
  pmc_pkg::pmc_apb_st_t st_nxt;
  logic [31:0]          prdata_nxt;
  logic                 pready_nxt;
  logic                 pslverr_nxt;
  logic                 commit;
  logic                 hit_any;
  logic [15:0]          rd_word;

  function automatic logic pin_hit(input logic [31:0] a, input int idx);
    logic [31:0] base;
    base = pmc_pkg::ADDR_PIN12_MODE + 32'(idx) * pmc_pkg::MODE_STRIDE;
    return a == base;
  endfunction

  function automatic logic clk_hit(input logic [31:0] a);
    return a == pmc_pkg::ADDR_CLK_SEL;
  endfunction

  // address decode and read mux
  always_comb begin
    hit_any = clk_hit(paddr);
    rd_word = 16'h0000;
    if (clk_hit(paddr)) begin
      rd_word = clk_r & pmc_pkg::CLK_WMASK;
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pin_hit(paddr, i)) begin
        hit_any = 1'b1;
        rd_word = mode_r[i] & pmc_pkg::MODE_WMASK;
      end
    end
  end

  // bus sequencing: answer on the second access cycle, write at that edge
  always_comb begin
    st_nxt      = st_r;
    pready_nxt  = 1'b0;
    pslverr_nxt = 1'b0;
    prdata_nxt  = 32'h0000_0000;
    commit      = 1'b0;
    case (st_r)
      pmc_pkg::ST_IDLE: begin
        if (psel && penable) begin
          st_nxt      = pmc_pkg::ST_ANSWER;
          pready_nxt  = 1'b1;
          pslverr_nxt = !hit_any;
          prdata_nxt  = pwrite ? 32'h0000_0000 : {16'h0000, rd_word};
        end
      end
      pmc_pkg::ST_ANSWER: begin
        st_nxt = pmc_pkg::ST_IDLE;
        commit = psel && penable && pwrite;
      end
      default: begin
        st_nxt = pmc_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_r    <= pmc_pkg::ST_IDLE;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      st_r    <= st_nxt;
      prdata  <= prdata_nxt;
      pready  <= pready_nxt;
      pslverr <= pslverr_nxt;
    end
  end

  // register writes; reserved mode bits never store
  always_comb begin
    clk_nxt = clk_r;
    if (commit && clk_hit(paddr)) begin
      clk_nxt = pwdata[15:0] & pmc_pkg::CLK_WMASK;
    end
    for (int i = 0; i < NUM_PINS; i++) begin
      mode_nxt[i] = mode_r[i];
      if (commit && pin_hit(paddr, i)) begin
        mode_nxt[i] = pwdata[15:0] & pmc_pkg::MODE_WMASK;
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_r <= pmc_pkg::CLK_RST;
      for (int i = 0; i < NUM_PINS; i++) begin
        mode_r[i] <= pmc_pkg::MODE_RST;
      end
    end else begin
      clk_r <= clk_nxt;
      for (int i = 0; i < NUM_PINS; i++) begin
        mode_r[i] <= mode_nxt[i];
      end
    end
  end

  // pad control per pin
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pad
    pmc_pad_ctrl u_pad (
      .core_clk (core_clk),
      .resetn   (resetn),
      .mode     (mode_r[g]),
      .adc_mode (adc_mode[g]),
      .pad      (pad_ctrl[g])
    );
  end

  // the pin's own mode must already be plain output; this block does not check it
  pmc_clk_route u_clk (
    .core_clk                 (core_clk),
    .resetn                   (resetn),
    .divclk_en                (clk_r[pmc_pkg::DIVCLK_BIT]),
    .rcclk_en                 (clk_r[pmc_pkg::RCCLK_BIT]),
    .xtalclk_en               (clk_r[pmc_pkg::XTALCLK_BIT]),
    .divided_system_clock     (divided_system_clock),
    .internal_rc_oscillator   (internal_rc_oscillator),
    .crystal_oscillator_clock (crystal_oscillator_clock),
    .port0_pin8_clk           (port0_pin8_clk),
    .port1_pin2_clk           (port1_pin2_clk),
    .port0_pin11_clk          (port0_pin11_clk)
  );

  // checks on pin 0 stand for every pin: the logic is one generate
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_wr_pin0;
    psel && !penable && pwrite && paddr == pmc_pkg::ADDR_PIN12_MODE
      ##1 psel && penable && pwrite && paddr == pmc_pkg::ADDR_PIN12_MODE
      ##1 pready;
  endsequence

  sequence s_rd_pin0;
    psel && penable && !pwrite && !pready && paddr == pmc_pkg::ADDR_PIN12_MODE
      ##1 pready;
  endsequence

  property p_reset_pull;
    $rose(resetn) |-> mode_r[0][9:8] == 2'h2 && pad_ctrl[0].pull_down;
  endproperty
  a_reset_pull : assert property (p_reset_pull)
    else $error("pull field not pull-down after reset");

  property p_pull_input;
    (!adc_mode[0] && mode_r[0][9:8] == 2'h1) |=>
      pad_ctrl[0].pull_up && !pad_ctrl[0].pull_down && !pad_ctrl[0].out_en;
  endproperty
  a_pull_input : assert property (p_pull_input)
    else $error("pull-up code did not select pull-up input");

  property p_pull_output;
    (!adc_mode[0] && mode_r[0][9:8] == 2'h3) |=>
      pad_ctrl[0].out_en && !pad_ctrl[0].pull_up && !pad_ctrl[0].pull_down;
  endproperty
  a_pull_output : assert property (p_pull_output)
    else $error("output code did not drive with resistors off");

  property p_adc_ignores_pull;
    adc_mode[0] |=> !pad_ctrl[0].out_en && !pad_ctrl[0].pull_up
      && !pad_ctrl[0].pull_down;
  endproperty
  a_adc_ignores_pull : assert property (p_adc_ignores_pull)
    else $error("pull field acted in analogue mode");

  property p_divclk_route;
    clk_r[9] |=> port0_pin8_clk == $past(divided_system_clock);
  endproperty
  a_divclk_route : assert property (p_divclk_route)
    else $error("divided clock not routed");

  property p_divclk_off;
    !clk_r[9] |=> !port0_pin8_clk;
  endproperty
  a_divclk_off : assert property (p_divclk_off)
    else $error("divided clock on pin while disabled");

  property p_rcclk_route;
    $past(clk_r[8]) ? (port1_pin2_clk == $past(internal_rc_oscillator))
                    : !port1_pin2_clk;
  endproperty
  a_rcclk_route : assert property (p_rcclk_route)
    else $error("rc oscillator pin wrong");

  property p_xtalclk_route;
    $past(clk_r[7]) ? (port0_pin11_clk == $past(crystal_oscillator_clock))
                    : !port0_pin11_clk;
  endproperty
  a_xtalclk_route : assert property (p_xtalclk_route)
    else $error("crystal clock pin wrong");

  property p_ostage;
    1'b1 |=> pad_ctrl[0].open_drain == $past(mode_r[0][10]);
  endproperty
  a_ostage : assert property (p_ostage)
    else $error("output stage type not following bit 10");

  property p_write_pin0;
    s_wr_pin0 |=> mode_r[0][10:0] == ($past(pwdata[10:0], 1) & 11'h73F);
  endproperty
  a_write_pin0 : assert property (p_write_pin0)
    else $error("mode write did not store");

  property p_read_pin0;
    s_rd_pin0 |-> prdata[7:6] == 2'h0 && prdata[5:0] == mode_r[0][5:0]
      && prdata[31:11] == 21'h0 && !pslverr;
  endproperty
  a_read_pin0 : assert property (p_read_pin0)
    else $error("mode read returned wrong value");

  property p_answer_once;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_answer_once : assert property (p_answer_once)
    else $error("bus answer not one wait state");

  property p_pull_none;
    (!adc_mode[0] && mode_r[0][9:8] == pmc_pkg::PULL_NONE) |=>
      !pad_ctrl[0].pull_up && !pad_ctrl[0].pull_down && !pad_ctrl[0].out_en;
  endproperty
  a_pull_none : assert property (p_pull_none)
    else $error("no-resistor code left a resistor or driver on");

  property p_pull_down;
    (!adc_mode[0] && mode_r[0][9:8] == pmc_pkg::PULL_DOWN) |=>
      pad_ctrl[0].pull_down && !pad_ctrl[0].pull_up && !pad_ctrl[0].out_en;
  endproperty
  a_pull_down : assert property (p_pull_down)
    else $error("pull-down code did not select pull-down input");

  property p_func_code;
    1'b1 |=> pad_ctrl[0].func == $past(mode_r[0][5:0]);
  endproperty
  a_func_code : assert property (p_func_code)
    else $error("function code not following bits 5:0");

  // writes carry ones in bits 7:6, so a lost mask shows up here
  property p_reserved_zero;
    mode_r[0][7:6] == 2'h0;
  endproperty
  a_reserved_zero : assert property (p_reserved_zero)
    else $error("reserved mode bits stored a one");

  property p_unmapped;
    psel && penable && !pready && !hit_any |=>
      pready && pslverr && prdata == 32'h0000_0000;
  endproperty
  a_unmapped : assert property (p_unmapped)
    else $error("unmapped access not refused");

  property p_clk_read;
    psel && penable && !pwrite && !pready && paddr == pmc_pkg::ADDR_CLK_SEL |=>
      pready && prdata[9:4] == clk_r[9:4] && prdata[3:0] == 4'h0 && prdata[31:10] == 22'h0;
  endproperty
  a_clk_read : assert property (p_clk_read)
    else $error("clock select read returned wrong value");
endmodule
`default_nettype wire

// ---- hdl/pmc_pkg.sv ----
// Purpose: shared constants and types for the pad mode and clock-out block
// Assumes: 32-bit APB addresses compared in full
// Notes:   mode words are 16 bits wide, upper bits of the bus word read zero
`default_nettype none
package pmc_pkg;
  // register byte addresses
  localparam logic [31:0] ADDR_PIN12_MODE = 32'h5002_0688;
  localparam logic [31:0] ADDR_PIN13_MODE = 32'h5002_068C;
  localparam logic [31:0] ADDR_PIN14_MODE = 32'h5002_0690;
  localparam logic [31:0] ADDR_PIN15_MODE = 32'h5002_0694;
  localparam logic [31:0] ADDR_CLK_SEL    = 32'h5002_06A0;
  localparam logic [31:0] MODE_STRIDE     = 32'h0000_0004;
  localparam int          MAX_PINS        = 4;

  // pin mode fields
  localparam int          OSTAGE_BIT      = 10;
  localparam int          PULL_MSB        = 9;
  localparam int          PULL_LSB        = 8;
  localparam int          FUNC_MSB        = 5;
  localparam logic [15:0] MODE_RST        = 16'h0200;
  localparam logic [15:0] MODE_WMASK      = 16'h073F;
  localparam logic [1:0]  PULL_NONE       = 2'h0;
  localparam logic [1:0]  PULL_UP         = 2'h1;
  localparam logic [1:0]  PULL_DOWN       = 2'h2;
  localparam logic [1:0]  PULL_OUTPUT     = 2'h3;

  // clock-to-pin fields
  localparam int          DIVCLK_BIT      = 9;
  localparam int          RCCLK_BIT       = 8;
  localparam int          XTALCLK_BIT     = 7;
  localparam logic [15:0] CLK_RST         = 16'h0000;
  localparam logic [15:0] CLK_WMASK       = 16'h03F0;

  typedef struct packed {
    logic       out_en;
    logic       pull_up;
    logic       pull_down;
    logic       open_drain;
    logic [5:0] func;
  } pmc_pad_t;

  localparam pmc_pad_t PAD_RST = '{out_en: 1'b0, pull_up: 1'b0, pull_down: 1'b1,
                                   open_drain: 1'b0, func: 6'h00};

  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_ANSWER = 1'b1
  } pmc_apb_st_t;
endpackage
`default_nettype wire

// ---- hdl/pmc_pad_ctrl.sv ----
// Purpose: turns one pin mode word into registered pad controls
// Assumes: adc_mode is synchronous to core_clk
// Notes:   one cycle from register change to pad change
`default_nettype none
module pmc_pad_ctrl (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic [15:0]       mode,
  input  wire logic              adc_mode,
  output var  pmc_pkg::pmc_pad_t pad
);
  pmc_pkg::pmc_pad_t pad_nxt;
  logic [1:0]        pull;

  always_comb begin
    pull               = mode[pmc_pkg::PULL_MSB:pmc_pkg::PULL_LSB];
    pad_nxt.pull_up    = (pull == pmc_pkg::PULL_UP) && !adc_mode;
    pad_nxt.pull_down  = (pull == pmc_pkg::PULL_DOWN) && !adc_mode;
    // output code drives the pin and leaves both resistors off
    pad_nxt.out_en     = (pull == pmc_pkg::PULL_OUTPUT) && !adc_mode;
    pad_nxt.open_drain = mode[pmc_pkg::OSTAGE_BIT];
    pad_nxt.func       = mode[pmc_pkg::FUNC_MSB:0];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pad <= pmc_pkg::PAD_RST;
    end else begin
      pad <= pad_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/pmc_clk_route.sv ----
// Purpose: gates the three source clocks onto their dedicated pins
// Assumes: source clocks are sampled as synchronous levels of core_clk
// Notes:   a flop sits in each path, so pins carry a sampled copy only
`default_nettype none
module pmc_clk_route (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic divclk_en,
  input  wire logic rcclk_en,
  input  wire logic xtalclk_en,
  input  wire logic divided_system_clock,
  input  wire logic internal_rc_oscillator,
  input  wire logic crystal_oscillator_clock,
  output var  logic port0_pin8_clk,
  output var  logic port1_pin2_clk,
  output var  logic port0_pin11_clk
);
  logic pin8_nxt;
  logic pin2_nxt;
  logic pin11_nxt;

  always_comb begin
    pin8_nxt  = divclk_en && divided_system_clock;
    pin2_nxt  = rcclk_en && internal_rc_oscillator;
    pin11_nxt = xtalclk_en && crystal_oscillator_clock;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      port0_pin8_clk  <= 1'b0;
      port1_pin2_clk  <= 1'b0;
      port0_pin11_clk <= 1'b0;
    end else begin
      port0_pin8_clk  <= pin8_nxt;
      port1_pin2_clk  <= pin2_nxt;
      port0_pin11_clk <= pin11_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- verification/pmc_pad_mode_clk_out_tb.sv ----
// Purpose: self-checking bench for the pad mode and clock-out block
// Assumes: apb master waits for pready under a bounded count
// Notes:   pins are checked just after a rising edge, before the flops move on
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, (e), (g)); end end
module pmc_pad_mode_clk_out_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic              core_clk;
  logic              resetn;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [3:0]        adc_mode;
  logic [2:0]        src;
  pmc_pkg::pmc_pad_t pad_ctrl [4];
  logic [2:0]        clk_pin;
  int                n_errors;
  int                check_count;

  pmc_pad_mode_clk_out #(.NUM_PINS(4)) dut (
    .core_clk                 (core_clk),
    .resetn                   (resetn),
    .psel                     (psel),
    .penable                  (penable),
    .pwrite                   (pwrite),
    .paddr                    (paddr),
    .pwdata                   (pwdata),
    .prdata                   (prdata),
    .pready                   (pready),
    .pslverr                  (pslverr),
    .adc_mode                 (adc_mode),
    .divided_system_clock     (src[2]),
    .internal_rc_oscillator   (src[1]),
    .crystal_oscillator_clock (src[0]),
    .pad_ctrl                 (pad_ctrl),
    .port0_pin8_clk           (clk_pin[2]),
    .port1_pin2_clk           (clk_pin[1]),
    .port0_pin11_clk          (clk_pin[0])
  );

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic complete_run();
    if (n_errors == 0 && check_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20) begin
      n_errors++;
      complete_run();
    end else begin
      rd      = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // pad and clock flops update one cycle after their cause
  task automatic settle();
    repeat (2) @(posedge core_clk);
  endtask

  function automatic pmc_pkg::pmc_pad_t exp_pad(logic [15:0] m, logic adc);
    pmc_pkg::pmc_pad_t p;
    p.out_en     = (m[9:8] == 2'h3) && !adc;
    p.pull_up    = (m[9:8] == 2'h1) && !adc;
    p.pull_down  = (m[9:8] == 2'h2) && !adc;
    p.open_drain = m[10];
    p.func       = m[5:0];
    return p;
  endfunction

  task automatic do_reset();
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
  endtask

  task automatic check_reset_values();
    logic [31:0] rd;
    logic        err;
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, 32'h5002_0688 + 32'(4 * p), 32'h0, rd, err);
      `CHK("mode reset", 32'h0000_0200, rd)
      `CHK("pad reset", exp_pad(16'h0200, 1'b0), pad_ctrl[p])
    end
    apb(1'b0, 32'h5002_06A0, 32'h0, rd, err);
    `CHK("clock select reset", 32'h0, rd)
    `CHK("clock pins reset", 3'h0, clk_pin)
  endtask

  // every pull code on every pin, with reserved bits set and analogue mode toggled
  task automatic test_modes();
    logic [31:0] rd;
    logic        err;
    logic [15:0] m;
    for (int p = 0; p < 4; p++) begin
      for (int c = 0; c < 4; c++) begin
        m = {5'h0, c[0], c[1:0], 2'h3, 6'(6'h3F - 5 * c - p)};
        apb(1'b1, 32'h5002_0688 + 32'(4 * p), {16'hFFFF, m}, rd, err);
        apb(1'b0, 32'h5002_0688 + 32'(4 * p), 32'h0, rd, err);
        `CHK("mode readback", {16'h0, m & 16'h073F}, rd)
        `CHK("mode pslverr", 1'b0, err)
        settle();
        `CHK("pad from mode", exp_pad(m, 1'b0), pad_ctrl[p])
        adc_mode[p] <= 1'b1;
        settle();
        `CHK("pad in analogue mode", exp_pad(m, 1'b1), pad_ctrl[p])
        adc_mode[p] <= 1'b0;
      end
    end
  endtask

  // each enable routes only its own source; dedicated pin modes live outside this block
  task automatic test_clock_out();
    logic [31:0] rd;
    logic        err;
    for (int b = 0; b < 3; b++) begin
      apb(1'b1, 32'h5002_06A0, 32'(16'h0080 << b), rd, err);
      src <= 3'h7;
      settle();
      `CHK("clock pins high source", 3'(1 << b), clk_pin)
      src <= 3'h0;
      settle();
      `CHK("clock pins low source", 3'h0, clk_pin)
    end
    apb(1'b1, 32'h5002_06A0, 32'hFFFF_FFFF, rd, err);
    apb(1'b0, 32'h5002_06A0, 32'h0, rd, err);
    `CHK("clock select readback", 32'h0000_03F0, rd)
    apb(1'b1, 32'h5002_06A0, 32'h0, rd, err);
    src <= 3'h7;
    settle();
    `CHK("clock pins disabled", 3'h0, clk_pin)
  endtask

  // unmapped places answer with an error and leave registers alone
  task automatic test_unmapped();
    logic [31:0] rd;
    logic        err;
    apb(1'b1, 32'h5002_06A4, 32'h0000_0380, rd, err);
    `CHK("unmapped write error", 1'b1, err)
    apb(1'b0, 32'h5002_069C, 32'h0, rd, err);
    `CHK("unmapped read error", 1'b1, err)
    `CHK("unmapped read data", 32'h0, rd)
    apb(1'b0, 32'h5002_06A0, 32'h0, rd, err);
    `CHK("clock select untouched", 32'h0, rd)
  endtask

  initial begin
    logic [31:0] rd;
    logic        err;
    resetn      = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 32'h0;
    pwdata      = 32'h0;
    adc_mode    = 4'h0;
    src         = 3'h0;
    n_errors    = 0;
    check_count = 0;
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    check_reset_values();
    test_modes();
    test_clock_out();
    test_unmapped();
    // a second reset in mid-run, with all clocks routed, must bring back the reset values
    apb(1'b1, 32'h5002_06A0, 32'h0000_0380, rd, err);
    src <= 3'h7;
    do_reset();
    check_reset_values();
    complete_run();
  end
endmodule
`undef CHK
`default_nettype wire
